/* File: verilog/fpu_err_pkg.sv */
// Purpose: shared constants, enumerations and carrier structs of the float error unit
// Assumes: 100 MHz sys_clk, one clock domain
// Notes:   image sizes are byte counts handed to the load/store side
package fpu_err_pkg;

    // clock and timing
    localparam int          CLK_PERIOD_NS  = 10;                  // sys_clk period
    localparam int          FLOAT_ERROR_OUT_N_PULSE_NS  = 50;                  // least width of the save pulse
    localparam logic [3:0]  FLOAT_ERROR_OUT_N_PULSE_CYC =
        4'((FLOAT_ERROR_OUT_N_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);  // rounded up

    // memory image sizes in bytes
    localparam logic [9:0]  IMG_LEGACY16_BYTES = 10'h05e;         // 94 bytes, 16-bit mode
    localparam logic [9:0]  IMG_LEGACY32_BYTES = 10'h06c;         // 108 bytes, 32-bit mode
    localparam logic [9:0]  IMG_EXT_BYTES      = 10'h200;         // 512 bytes
    localparam logic [3:0]  EXT_ALIGN_MASK     = 4'hf;            // 16-byte boundary

    // vectors
    localparam logic [7:0]  VEC_NUMERIC   = 8'h10;                // numeric error, 16
    localparam logic [7:0]  VEC_DNA_DEF   = 8'h07;                // device not available
    localparam logic [7:0]  VEC_ALIGN_DEF = 8'h0d;                // misaligned image fault

    // reset values
    localparam logic        PEND_RESET  = 1'b0;                   // nothing pending
    localparam logic        FLOAT_ERROR_OUT_N_N_RESET = 1'b1;                  // error pin idle high

    // instruction classes seen by the unit
    typedef enum logic [2:0] {
        K_FP_WAIT   = 3'h0,                                       // arithmetic or wait
        K_NOWAIT    = 3'h1,                                       // other no-wait control op
        K_LSAVE_W   = 3'h2,                                       // legacy_wait_save
        K_LSAVE_NW  = 3'h3,                                       // legacy_nowait_save
        K_LRESTORE  = 3'h4,                                       // legacy_restore
        K_XSAVE     = 3'h5,                                       // extended_save
        K_XRESTORE  = 3'h6                                        // extended_restore
    } instr_kind_t;

    typedef enum logic [2:0] {
        OUT_DONE     = 3'h0,                                      // executed
        OUT_DNA      = 3'h1,                                      // device_not_available_fault
        OUT_ALIGN    = 3'h2,                                      // misaligned extended image
        OUT_VEC16    = 3'h3,                                      // internal numeric vector
        OUT_EXTERNAL = 3'h4                                       // frozen, external irq path
    } outcome_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,                                        // accepting instructions
        ST_FROZEN = 2'b10                                         // waiting for external irq
    } ctl_state_t;

    typedef struct packed {
        logic        valid;                                       // one-cycle issue strobe
        instr_kind_t kind;                                        // instruction class
        logic        mode32;                                      // 32-bit operand mode
        logic [31:0] base;                                        // image base address
    } issue_t;

    typedef struct packed {
        logic        done;                                        // one-cycle answer strobe
        outcome_t    outcome;                                     // what happened
        logic [7:0]  vector;                                      // vector when faulting
    } resp_t;

    typedef struct packed {
        logic        valid;                                       // one-cycle transfer strobe
        logic        write;                                       // save when high
        logic        ext_format;                                  // extended layout when high
        logic [31:0] base;                                        // image base
        logic [9:0]  bytes;                                       // image length
    } xfer_t;

    // extended image classes
    function automatic logic is_ext(input instr_kind_t k);
        return (k == K_XSAVE) || (k == K_XRESTORE);
    endfunction : is_ext

    // no-wait forms never wait on pending errors
    function automatic logic is_nowait(input instr_kind_t k);
        return (k == K_NOWAIT) || (k == K_LSAVE_NW);
    endfunction : is_nowait

endpackage : fpu_err_pkg

/* File: verilog/bit_sync.sv */
// Purpose: two flip-flop synchroniser, also used for reset release
// Assumes: d may change at any time relative to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module bit_sync #(
    parameter logic INIT = 1'b0                                   // value held under reset
) (
    input  wire logic clk,                                        // sampling clock
    input  wire logic rst_n,                                      // async reset, low active
    input  wire logic d,                                          // asynchronous input
    output logic      q                                           // synchronised copy
);
    typedef struct packed {
        logic meta;                                               // first stage
        logic out;                                                // second stage
    } sync_state_t;

    sync_state_t st;                                              // registered state
    sync_state_t next_st;                                         // next state

    // shift one stage per edge
    always_comb begin
        next_st.meta = d;
        next_st.out  = st.meta;
    end

    // constant reset only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= {INIT, INIT};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.out;
endmodule : bit_sync

/* File: verilog/img_planner.sv */
// Purpose: size, layout and alignment check of a state image
// Assumes: kind is valid only when the issue strobe is high
// Notes:   purely combinational, no state
`timescale 1ns/1ps
module img_planner
    import fpu_err_pkg::*;
(
    input  instr_kind_t kind,                                     // instruction class
    input  wire logic   mode32,                                   // operand size mode
    input  wire [31:0]  base,                                     // image base
    output logic [9:0]  bytes,                                    // image length
    output logic        ext_format,                               // extended layout
    output logic        align_ok,                                 // base usable
    output logic        mem_op                                    // touches memory
);
    // legacy images depend on mode, extended ones are fixed
    always_comb begin
        ext_format = is_ext(kind);
        mem_op     = (kind != K_FP_WAIT) && (kind != K_NOWAIT);
        if (ext_format) begin
            bytes    = IMG_EXT_BYTES;
            align_ok = (base[3:0] & EXT_ALIGN_MASK) == 4'h0;
        end else begin
            bytes    = mode32 ? IMG_LEGACY32_BYTES : IMG_LEGACY16_BYTES;
            align_ok = 1'b1;                                      // legacy has no check here
        end
    end
endmodule : img_planner

/* File: verilog/fpu_error_signaling.sv */
// Purpose: records numeric errors, delivers them and plans state images
// Assumes: core issues one instruction at a time and waits for resp.done
// Notes:   software clears a pending error only through save or restore
`timescale 1ns/1ps
module fpu_error_signaling
    import fpu_err_pkg::*;
#(
    parameter logic [7:0] VEC_DNA   = VEC_DNA_DEF,                // fault vector, dna
    parameter logic [7:0] VEC_ALIGN = VEC_ALIGN_DEF               // fault vector, alignment
) (
    input  wire logic   sys_clk,                                  // 100 MHz clock
    input  wire logic   rstn,                                     // async reset, low active
    input  issue_t      instr,                                    // instruction issue
    input  wire logic   native_error_mode,                        // control_reg_zero bit
    input  wire logic   dev_na,                                   // unit not available
    input  wire logic   exc_event,                                // unmasked error recorded
    input  wire logic   image_pend,                               // restored image has error
    input  wire logic   coproc_error_n,                           // coprocessor error pin
    input  wire logic   ext_intr_taken,                           // core took external irq
    output resp_t       resp,                                     // instruction answer
    output xfer_t       xfer,                                     // image transfer request
    output logic        reinit,                                   // clear the unit, pulse
    output logic        exc_pending,                              // error pending, level
    output logic        float_error_out_n,                        // error pin, low active
    output logic        frozen                                    // held for external irq
);
    typedef struct packed {
        ctl_state_t state;                                        // control state
        logic       pending;                                      // internal error record
        logic [3:0] pulse;                                        // save pulse counter
        resp_t      resp;                                         // registered answer
        xfer_t      xfer;                                         // registered transfer
        logic       reinit;                                       // registered reinit
        logic       float_error_out_n_n;                                       // registered pin level
    } unit_state_t;

    unit_state_t st;                                              // registered state
    unit_state_t next_st;                                         // next state
    logic        rst_n;                                           // released reset
    logic        coproc_sync_n;                                   // synchronised pin
    logic [9:0]  plan_bytes;                                      // image length
    logic        plan_ext;                                        // extended layout
    logic        plan_align_ok;                                   // base aligned
    logic        plan_mem;                                        // memory operation
    logic        take;                                            // instruction accepted
    logic        pend_src;                                        // error seen by wait ops

    // reset release through two stages
    bit_sync #(.INIT(1'b0)) u_rst_sync (
        .clk   (sys_clk),
        .rst_n (rstn),
        .d     (1'b1),
        .q     (rst_n)
    );

    // coprocessor pin comes from another chip
    bit_sync #(.INIT(1'b1)) u_err_sync (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .d     (coproc_error_n),
        .q     (coproc_sync_n)
    );

    img_planner u_plan (
        .kind       (instr.kind),
        .mode32     (instr.mode32),
        .base       (instr.base),
        .bytes      (plan_bytes),
        .ext_format (plan_ext),
        .align_ok   (plan_align_ok),
        .mem_op     (plan_mem)
    );

    // valid while frozen is dropped, so the core must wait for resp.done
    assign take = instr.valid && (st.state == ST_IDLE);

    // native mode looks only at the internal record, so no pin delay can
    // make a stale error land after execution moved on
    assign pend_src = st.pending || (!native_error_mode && !coproc_sync_n);

    // instruction decision and error bookkeeping
    always_comb begin
        next_st             = st;
        next_st.resp.done   = 1'b0;
        next_st.xfer.valid  = 1'b0;
        next_st.reinit      = 1'b0;
        if (st.pulse != 4'h0) begin
            next_st.pulse = st.pulse - 4'h1;                      // pulse runs down
        end
        case (st.state)
            ST_IDLE: begin
                if (take) begin
                    next_st.resp.done   = 1'b1;
                    next_st.resp.vector = 8'h00;
                    if (dev_na) begin
                        // dna wins so the error is handled in its own context
                        next_st.resp.outcome = OUT_DNA;
                        next_st.resp.vector  = VEC_DNA;
                    end else if (plan_ext && !plan_align_ok) begin
                        // faulted before any access, state untouched
                        next_st.resp.outcome = OUT_ALIGN;
                        next_st.resp.vector  = VEC_ALIGN;
                    end else if (!is_nowait(instr.kind) && pend_src) begin
                        // blocked op: the mode decides who delivers
                        if (native_error_mode) begin
                            next_st.resp.outcome = OUT_VEC16;
                            next_st.resp.vector  = VEC_NUMERIC;
                        end else begin
                            // compat: pin and controller deliver, hold the op
                            next_st.resp.outcome = OUT_EXTERNAL;
                            next_st.resp.vector  = VEC_NUMERIC;
                            next_st.state        = ST_FROZEN;
                        end
                    end else begin
                        // executes; plain no-wait ops leave pending as is, legacy saves clear it
                        next_st.resp.outcome = OUT_DONE;
                        next_st.xfer.valid   = plan_mem;
                        next_st.xfer.write   = (instr.kind == K_LSAVE_W) ||
                                               (instr.kind == K_LSAVE_NW) ||
                                               (instr.kind == K_XSAVE);
                        next_st.xfer.ext_format = plan_ext;
                        next_st.xfer.base    = instr.base;
                        next_st.xfer.bytes   = plan_bytes;
                        // side effects of an executed op
                        case (instr.kind)
                            K_LSAVE_W, K_LSAVE_NW: begin
                                next_st.reinit  = 1'b1;
                                next_st.pending = 1'b0;
                                if ((instr.kind == K_LSAVE_NW) && pend_src &&
                                    !native_error_mode) begin
                                    next_st.pulse = FLOAT_ERROR_OUT_N_PULSE_CYC;
                                end
                            end
                            K_LRESTORE, K_XRESTORE: begin
                                next_st.pending = image_pend;
                            end
                            default: begin
                                // extended save and plain ops keep live state
                                next_st.pending = st.pending;
                            end
                        endcase
                    end
                end
            end
            ST_FROZEN: begin
                if (ext_intr_taken) begin
                    next_st.state = ST_IDLE;                      // handler entered
                end
            end
            default: begin
                next_st.state = ST_IDLE;                          // illegal code recovery
            end
        endcase
        // a new error in the clearing cycle still wins
        if (exc_event) begin
            next_st.pending = 1'b1;
        end
        // pin follows the record in either mode, plus the save pulse
        next_st.float_error_out_n_n = !(next_st.pending || (next_st.pulse != 4'h0));
    end

    // single state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.state   <= ST_IDLE;
            st.pending <= PEND_RESET;
            st.float_error_out_n_n  <= FLOAT_ERROR_OUT_N_N_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs come straight from the state register
    assign resp              = st.resp;
    assign xfer              = st.xfer;
    assign reinit            = st.reinit;
    assign exc_pending       = st.pending;
    assign float_error_out_n = st.float_error_out_n_n;
    assign frozen            = (st.state == ST_FROZEN);

    // checks
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // issue meets an unavailable unit
    sequence s_dna;
        take && dev_na;
    endsequence
    // extended image on a bad boundary
    sequence s_misaligned;
        take && !dev_na && plan_ext && !plan_align_ok;
    endsequence
    // waiting op over a pending error
    sequence s_blocked;
        take && !dev_na && !is_nowait(instr.kind) && pend_src &&
            !(plan_ext && !plan_align_ok);
    endsequence
    // compat no-wait save with an error pending
    sequence s_compat_nw_save;
        take && !dev_na && (instr.kind == K_LSAVE_NW) && pend_src && !native_error_mode;
    endsequence
    // legacy restore that is free to run
    sequence s_restore;
        take && !dev_na && (instr.kind == K_LRESTORE) && !pend_src;
    endsequence
    // frozen and waiting for the handler
    sequence s_frozen_hold;
        frozen && !ext_intr_taken;
    endsequence
    // native issue with a clean internal record
    sequence s_native_clean;
        take && native_error_mode && !dev_na && !exc_pending;
    endsequence
    // plain no-wait op over a pending error
    sequence s_nw_pending;
        take && !dev_na && (instr.kind == K_NOWAIT) && exc_pending;
    endsequence

    AST_LEGACY_SIZE: assert property (xfer.valid && !xfer.ext_format |->
        xfer.bytes == ($past(instr.mode32) ? IMG_LEGACY32_BYTES : IMG_LEGACY16_BYTES))
        else $error("legacy image size wrong");
    AST_EXT_SIZE: assert property (xfer.valid && xfer.ext_format |->
        xfer.bytes == IMG_EXT_BYTES && xfer.base[3:0] == 4'h0)
        else $error("extended image size or base wrong");
    AST_ALIGN_FAULT: assert property (s_misaligned |=>
        resp.done && resp.outcome == OUT_ALIGN && !xfer.valid && !reinit)
        else $error("misaligned image not faulted cleanly");

    // side effects of saves and restores on the live state
    AST_REINIT: assert property (reinit |->
        xfer.write && !xfer.ext_format && (!exc_pending || $past(exc_event)))
        else $error("reinit without legacy save");
    AST_XSAVE_KEEP: assert property (xfer.valid && xfer.write && xfer.ext_format |->
        !reinit && exc_pending == ($past(exc_pending) || $past(exc_event)))
        else $error("extended save changed state");
    AST_FORMAT: assert property (xfer.valid |->
        xfer.ext_format == is_ext(instr_kind_t'($past(instr.kind))))
        else $error("image layout mismatch");

    // delivery priority and paths
    AST_DNA_FIRST: assert property (s_dna |=>
        resp.outcome == OUT_DNA && resp.vector == VEC_DNA && !xfer.valid)
        else $error("dna not taken first");
    AST_DELIVER: assert property (s_blocked |=> resp.done && !xfer.valid &&
        resp.vector == VEC_NUMERIC &&
        (($past(native_error_mode) && resp.outcome == OUT_VEC16 && !frozen) ||
         (!$past(native_error_mode) && resp.outcome == OUT_EXTERNAL && frozen)))
        else $error("numeric error delivery wrong");
    AST_NOWAIT: assert property (take && !dev_na && is_nowait(instr.kind) |=>
        resp.outcome != OUT_VEC16 && resp.outcome != OUT_EXTERNAL)
        else $error("no-wait op took numeric error");
    AST_RESTORE: assert property (s_restore |=>
        exc_pending == ($past(image_pend) || $past(exc_event)))
        else $error("restore did not reload pending");

    // error pin, both modes
    AST_FLOAT_ERROR_OUT_N_LEVEL: assert property (exc_pending |-> !float_error_out_n)
        else $error("error pin idle while pending");
    AST_SAVE_PULSE: assert property (s_compat_nw_save |=> !float_error_out_n [*5])
        else $error("save pulse too short");

    // frozen op waits for the external handler only
    AST_FROZEN_HOLD: assert property (s_frozen_hold |=> frozen && !resp.done)
        else $error("frozen state left without handler");
    AST_FROZEN_EXIT: assert property (frozen && ext_intr_taken |=> !frozen)
        else $error("frozen state kept after handler entry");
    AST_FROZEN_QUIET: assert property (frozen |-> !xfer.valid && !reinit)
        else $error("image transfer while frozen");

    // native mode: the pin plays no part and nothing freezes
    AST_NATIVE_PIN: assert property (s_native_clean |=>
        resp.outcome != OUT_VEC16 && resp.outcome != OUT_EXTERNAL)
        else $error("native op blocked without internal error");
    AST_NATIVE_NO_FREEZE: assert property (take && native_error_mode |=> !frozen)
        else $error("native op waited on external path");

    // pending record survives plain no-wait ops, legacy saves always reinit
    AST_NW_KEEP: assert property (s_nw_pending |=> exc_pending)
        else $error("no-wait op dropped pending error");
    AST_SAVE_REINIT: assert property (xfer.valid && xfer.write && !xfer.ext_format |->
        reinit)
        else $error("legacy save without reinit");
endmodule : fpu_error_signaling

/* File: testbench/coproc_model.sv */
// Purpose: far-side coprocessor that flags recorded errors on its pin
// Assumes: one clock, bench says when to record and clear
// Notes:   pin idles high, as with a board pull-up
`timescale 1ns/1ps
module coproc_model (
    input  wire logic clk,   // core clock
    input  wire logic rec,   // unmasked error recorded
    input  wire logic clr,   // handler cleared it
    output logic      err_n  // error pin, low active
);
    initial err_n = 1'b1;    // idle level
    // error is held until the handler clears it
    always @(posedge clk) begin
        if (clr) err_n <= 1'b1;
        else if (rec) err_n <= 1'b0;
    end
endmodule : coproc_model

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the float error unit
// Assumes: inputs change on falling edges only
// Notes:   pin and vector figures from the package
`timescale 1ns/1ps
module tb;
    import fpu_err_pkg::*;
    logic   sys_clk, rstn, nem, dev_na, exc_event, image_pend, eit, rec, clr;
    logic   reinit, exc_pending, float_error_out_n_n, frozen, cop_n;  // design and model outputs
    issue_t instr;                                       // issue port
    resp_t  resp;                                        // answer port
    xfer_t  xfer;                                        // image request
    int     n_fail = 0, tests_run = 0, cyc = 0;          // counters

    fpu_error_signaling i_fpu_error_signaling (.sys_clk(sys_clk), .rstn(rstn),
        .instr(instr), .native_error_mode(nem), .dev_na(dev_na), .exc_event(exc_event),
        .image_pend(image_pend), .coproc_error_n(cop_n), .ext_intr_taken(eit),
        .resp(resp), .xfer(xfer), .reinit(reinit), .exc_pending(exc_pending),
        .float_error_out_n(float_error_out_n_n), .frozen(frozen));
    coproc_model i_coproc_model (.clk(sys_clk), .rec(rec), .clr(clr), .err_n(cop_n));

    initial begin sys_clk = 1'b0; forever #5 sys_clk = ~sys_clk; end
    // a hang counts as a failure
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin n_fail++; end_sim(); end
    end

    task automatic end_sim();
        $display("tests %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one-cycle issue; answer is sampled one cycle later
    task automatic issue(input instr_kind_t k, input logic m32, input logic [31:0] b);
        @(negedge sys_clk) instr <= '{1'b1, k, m32, b};
        @(negedge sys_clk) instr.valid <= 1'b0;
    endtask : issue

    // one-cycle pulse on any bench input
    task automatic pulse(ref logic s);
        @(negedge sys_clk) s = 1'b1;
        @(negedge sys_clk) s = 1'b0;
    endtask : pulse

    task automatic t_sizes();
        issue(K_LSAVE_NW, 1'b0, 32'h100); check(xfer.bytes, 94);
        check(reinit, 1);
        issue(K_LSAVE_W, 1'b1, 32'h100); check(xfer.bytes, 108);
        check(reinit, 1);
        issue(K_XSAVE, 1'b1, 32'h200);
        check({xfer.write, xfer.ext_format, xfer.bytes}, 12'he00);
        check(reinit, 0);
        issue(K_XRESTORE, 1'b0, 32'h210); check({xfer.write, xfer.bytes}, 11'h200);
        check(xfer.base, 32'h210);
        issue(K_LRESTORE, 1'b1, 32'h300); check({xfer.ext_format, xfer.bytes}, 11'h06c);
        issue(K_XSAVE, 1'b1, 32'h208);
        check({resp.outcome, resp.vector}, {OUT_ALIGN, 8'h0d});
        check(xfer.valid, 0);
        $display("test sizes done");
    endtask : t_sizes

    task automatic t_native();
        nem = 1'b1;
        pulse(exc_event);
        @(negedge sys_clk) check({exc_pending, float_error_out_n_n}, 2'b10);
        issue(K_NOWAIT, 1'b1, 32'h0); check(resp.outcome, OUT_DONE);
        check(exc_pending, 1);
        dev_na = 1'b1;
        issue(K_FP_WAIT, 1'b1, 32'h0);
        check({resp.outcome, resp.vector}, {OUT_DNA, 8'h07});
        dev_na = 1'b0;
        issue(K_FP_WAIT, 1'b1, 32'h0);
        check({resp.outcome, resp.vector, frozen}, {OUT_VEC16, 9'h020});
        issue(K_LSAVE_NW, 1'b1, 32'h0); check(resp.outcome, OUT_DONE);
        @(negedge sys_clk) check(exc_pending, 0);
        pulse(rec);
        repeat (3) @(negedge sys_clk);
        issue(K_FP_WAIT, 1'b1, 32'h0); check(resp.outcome, OUT_DONE);
        pulse(clr);
        image_pend = 1'b1;
        issue(K_LRESTORE, 1'b1, 32'h0); image_pend = 1'b0;
        issue(K_FP_WAIT, 1'b1, 32'h0); check(resp.outcome, OUT_VEC16);
        issue(K_LSAVE_W, 1'b1, 32'h0);
        check(resp.outcome, OUT_VEC16);
        $display("test native done");
    endtask : t_native

    task automatic t_compat();
        nem = 1'b0;
        pulse(exc_event);
        check(float_error_out_n_n, 0);
        issue(K_LSAVE_NW, 1'b1, 32'h0); check({resp.outcome, float_error_out_n_n}, {OUT_DONE, 1'b0});
        repeat (4) @(negedge sys_clk);
        check(float_error_out_n_n, 0);
        @(negedge sys_clk) check(float_error_out_n_n, 1);
        pulse(rec);
        repeat (3) @(negedge sys_clk);
        issue(K_NOWAIT, 1'b1, 32'h0); check(resp.outcome, OUT_DONE);
        issue(K_FP_WAIT, 1'b1, 32'h0);
        check({resp.outcome, resp.vector, frozen}, {OUT_EXTERNAL, 9'h021});
        issue(K_FP_WAIT, 1'b1, 32'h0); check(resp.done, 0);
        pulse(clr);
        pulse(eit); check(frozen, 0);
        $display("test compat done");
    endtask : t_compat

    initial begin
        {rstn, nem, dev_na, exc_event, image_pend, eit, rec, clr} = '0;
        instr = '0;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(float_error_out_n_n, 1);
        t_sizes();
        t_native();
        t_compat();
        end_sim();
    end
endmodule : tb
